// >>> core/sar_adc_consts.svh
// Register map, field positions, reset values and timing counts for the SAR ADC sequencer
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define ADC_OFS_CHSEL 12'h000
`define ADC_OFS_CTRL 12'h004
`define ADC_OFS_RES_LO 12'h008
`define ADC_OFS_RES_HI 12'h00c

`define ADC_BIT_ENABLE 7
`define ADC_BIT_START 6
`define ADC_BIT_FREE 5
`define ADC_BIT_DONE 4
`define ADC_BIT_IRQEN 3

`define ADC_CTRL_RESET 8'h00
`define ADC_CHSEL_RESET 3'h0
`define ADC_RESULT_RESET 10'h000

`define ADC_DUMMY_EXTRA 5'd12
`define ADC_SAMPLE_CYC 5'd2
`define ADC_READY_CYC 5'd13

`endif

// >>> core/sar_adc_pkg.sv
// Types shared by the SAR ADC sequencer
`default_nettype none
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_EDGE,
    ST_CONVERT,
    ST_RECOVER
  } seq_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic sample_hold;
    logic [2:0] channel;
    logic [9:0] trial;
    logic dac_valid;
  } analog_ctl_t;

  typedef struct packed {
    seq_state_t st;
    logic enable;
    logic start;
    logic free_run;
    logic done_flag;
    logic irq_en;
    logic [2:0] div_sel;
    logic [2:0] chsel_sw;
    logic [2:0] chsel_act;
    logic [9:0] result;
    logic locked;
    logic first_pending;
    logic [6:0] presc;
    logic adc_clk;
    logic adc_rise;
    logic [4:0] cyc;
    logic [4:0] samp_cyc;
    logic [4:0] ready_cyc;
    logic [9:0] sar;
    logic [3:0] bit_idx;
    logic cmp_s1;
    logic cmp_s2;
    logic halt_prev;
    logic idle_conv;
    logic irq;
    logic wake;
    apb_rsp_t rsp;
    analog_ctl_t ana;
  } adc_state_t;

endpackage
`default_nettype wire

// >>> core/sar_adc_sequencer.sv
// SAR ADC sequencer: APB registers, prescaler, conversion timing, result lock
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "sar_adc_consts.svh"
`default_nettype none
module sar_adc_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire sar_adc_pkg::apb_req_t apb_req,
  output var sar_adc_pkg::apb_rsp_t apb_rsp,
  input wire logic comparator_in,
  input wire logic cpu_halted,
  input wire logic irq_ack,
  output var sar_adc_pkg::analog_ctl_t analog_ctl,
  output logic conversion_done_irq,
  output logic wake_request
);
  import sar_adc_pkg::*;

  adc_state_t s_r;
  adc_state_t s_nxt;

  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [6:0] div_half;
  logic conv_end;
  logic launch;
  logic [4:0] cyc_next;

  ////////////////////////////////////////////////////////////////////////////
  // Divider: the converter clock toggles every div_half system clocks
  always_comb begin
    unique case (s_r.div_sel)
      3'd0, 3'd1: div_half = 7'd1;
      3'd2: div_half = 7'd2;
      3'd3: div_half = 7'd4;
      3'd4: div_half = 7'd8;
      3'd5: div_half = 7'd16;
      3'd6: div_half = 7'd32;
      3'd7: div_half = 7'd64;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    wbyte = apb_req.pwdata[7:0];
    conv_end = 1'b0;
    launch = 1'b0;
    cyc_next = s_r.cyc + 5'd1;

    // Comparator is asynchronous to us
    s_nxt.cmp_s1 = comparator_in;
    s_nxt.cmp_s2 = s_r.cmp_s1;
    s_nxt.halt_prev = cpu_halted;

    // Prescaler
    s_nxt.adc_rise = 1'b0;
    if (!s_r.enable) begin
      s_nxt.presc = 7'd0;
      s_nxt.adc_clk = 1'b0;
    end else if (s_r.presc + 7'd1 >= div_half) begin
      s_nxt.presc = 7'd0;
      s_nxt.adc_clk = !s_r.adc_clk;
      s_nxt.adc_rise = !s_r.adc_clk;
    end else begin
      s_nxt.presc = s_r.presc + 7'd1;
    end

    // APB: one-wait-state slave, one-cycle pready in the access phase
    s_nxt.rsp.pready = apb_req.psel && apb_req.penable && !s_r.rsp.pready;
    s_nxt.rsp.pslverr = 1'b0;
    s_nxt.rsp.prdata = 32'h0000_0000;
    if (rd_acc && !s_r.rsp.pready) begin
      unique case (apb_req.paddr)
        `ADC_OFS_CHSEL: s_nxt.rsp.prdata = {29'h0, s_r.chsel_sw};
        `ADC_OFS_CTRL: s_nxt.rsp.prdata = {24'h0, s_r.enable, s_r.start,
          s_r.free_run, s_r.done_flag, s_r.irq_en, s_r.div_sel};
        `ADC_OFS_RES_LO: begin
          s_nxt.rsp.prdata = {24'h0, s_r.result[7:0]};
        end
        `ADC_OFS_RES_HI: begin
          s_nxt.rsp.prdata = {30'h0, s_r.result[9:8]};
        end
        default: s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    // Error decode rides with pready; write side effects land on the
    // edge that completes the transfer
    if (wr_acc && !s_r.rsp.pready) begin
      unique case (apb_req.paddr)
        `ADC_OFS_CHSEL, `ADC_OFS_CTRL, `ADC_OFS_RES_LO, `ADC_OFS_RES_HI: ;
        default: s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    if (rd_acc && s_r.rsp.pready && apb_req.paddr == `ADC_OFS_RES_LO) begin
      s_nxt.locked = 1'b1;
    end
    if (rd_acc && s_r.rsp.pready && apb_req.paddr == `ADC_OFS_RES_HI) begin
      s_nxt.locked = 1'b0;
    end
    if (wr_acc && s_r.rsp.pready) begin
      unique case (apb_req.paddr)
        `ADC_OFS_CHSEL: s_nxt.chsel_sw = wbyte[2:0];
        `ADC_OFS_CTRL: begin
          s_nxt.enable = wbyte[`ADC_BIT_ENABLE];
          if (wbyte[`ADC_BIT_ENABLE] && !s_r.enable) begin
            s_nxt.first_pending = 1'b1;
          end
          if (wbyte[`ADC_BIT_START]) begin
            s_nxt.start = 1'b1;
          end
          s_nxt.free_run = wbyte[`ADC_BIT_FREE];
          if (wbyte[`ADC_BIT_DONE]) begin
            s_nxt.done_flag = 1'b0;
          end
          s_nxt.irq_en = wbyte[`ADC_BIT_IRQEN];
          s_nxt.div_sel = wbyte[2:0];
        end
        default: ;
      endcase
    end
    if (irq_ack) begin
      s_nxt.done_flag = 1'b0;
    end

    // Noise-reduced conversion on entry to idle
    if (cpu_halted && !s_r.halt_prev && s_r.enable && !s_r.start &&
        !s_r.free_run && s_r.irq_en && s_r.st == ST_IDLE) begin
      s_nxt.start = 1'b1;
      s_nxt.idle_conv = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; IDLE and a restart from RECOVER advance on any system clock, other steps on converter clock rising edges
    s_nxt.ana.sample_hold = 1'b0;
    s_nxt.ana.dac_valid = 1'b0;
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.start && s_r.enable) begin
          s_nxt.st = ST_WAIT_EDGE;
        end
      end
      ST_WAIT_EDGE: begin
        if (s_r.adc_rise) begin
          launch = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (s_r.adc_rise) begin
          s_nxt.cyc = cyc_next;
          if (s_r.cyc == s_r.samp_cyc - 5'd1) begin
            // Hold closed half a cycle earlier, at the falling edge
            s_nxt.ana.sample_hold = 1'b0;
            s_nxt.sar = 10'h200;
            s_nxt.bit_idx = 4'd9;
          end else if (s_r.cyc >= s_r.samp_cyc &&
                       s_r.cyc < s_r.ready_cyc - 5'd1) begin
            s_nxt.sar[s_r.bit_idx] = s_r.cmp_s2;
            if (s_r.bit_idx != 4'd0) begin
              s_nxt.sar[s_r.bit_idx - 4'd1] = 1'b1;
              s_nxt.bit_idx = s_r.bit_idx - 4'd1;
            end
          end
          if (s_r.cyc == s_r.ready_cyc - 5'd1) begin
            conv_end = 1'b1;
          end
        end else if (!s_r.adc_clk && s_r.presc == 7'd0 &&
                     s_r.cyc == s_r.samp_cyc - 5'd1) begin
          s_nxt.ana.sample_hold = 1'b1;
        end
        s_nxt.ana.dac_valid = s_r.cyc >= s_r.samp_cyc;
      end
      ST_RECOVER: begin
        if (s_r.start) begin
          launch = 1'b1;
        end else if (s_r.adc_rise) begin
          s_nxt.st = ST_IDLE;
        end
      end
    endcase

    if (conv_end) begin
      s_nxt.start = 1'b0;
      s_nxt.done_flag = 1'b1;
      s_nxt.chsel_act = s_r.chsel_sw;
      if (!s_nxt.locked) begin
        s_nxt.result = s_r.sar;
      end
      if (s_r.idle_conv) begin
        s_nxt.wake = 1'b1;
        s_nxt.idle_conv = 1'b0;
      end
      if (s_r.free_run) begin
        launch = 1'b1;
      end else begin
        s_nxt.st = ST_RECOVER;
      end
    end

    if (launch) begin
      s_nxt.st = ST_CONVERT;
      s_nxt.start = 1'b1;
      s_nxt.cyc = 5'd0;
      s_nxt.first_pending = 1'b0;
      s_nxt.ana.channel = conv_end ? s_r.chsel_sw : s_r.chsel_act;
      s_nxt.chsel_act = s_nxt.ana.channel;
      if (s_r.first_pending) begin
        s_nxt.samp_cyc = `ADC_SAMPLE_CYC + `ADC_DUMMY_EXTRA;
        s_nxt.ready_cyc = `ADC_READY_CYC + `ADC_DUMMY_EXTRA;
      end else begin
        s_nxt.samp_cyc = `ADC_SAMPLE_CYC;
        s_nxt.ready_cyc = `ADC_READY_CYC;
      end
    end
    if (s_r.st == ST_IDLE || s_r.st == ST_RECOVER) begin
      s_nxt.chsel_act = s_r.chsel_sw;
    end
    s_nxt.ana.trial = s_nxt.sar;

    if (!cpu_halted) begin
      s_nxt.wake = 1'b0;
    end
    s_nxt.irq = s_nxt.done_flag && s_nxt.irq_en;

    // Disabling terminates any conversion in flight
    if (!s_nxt.enable) begin
      s_nxt.st = ST_IDLE;
      s_nxt.start = 1'b0;
      s_nxt.idle_conv = 1'b0;
      s_nxt.ana.sample_hold = 1'b0;
      s_nxt.ana.dac_valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.samp_cyc <= `ADC_SAMPLE_CYC;
      s_r.ready_cyc <= `ADC_READY_CYC;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp = s_r.rsp;
  assign analog_ctl = s_r.ana;
  assign conversion_done_irq = s_r.irq;
  assign wake_request = s_r.wake;

endmodule
`default_nettype wire

// >>> tb/sar_adc_monitor.sv
// Port checker for the SAR ADC sequencer
`default_nettype none
module sar_adc_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire sar_adc_pkg::apb_req_t apb_req,
  input wire sar_adc_pkg::apb_rsp_t apb_rsp,
  input wire logic comparator_in,
  input wire logic cpu_halted,
  input wire logic irq_ack,
  input wire sar_adc_pkg::analog_ctl_t analog_ctl,
  input wire logic conversion_done_irq,
  input wire logic wake_request
);
  import sar_adc_pkg::*;
  logic [5:0] gap_r;
  logic [5:0] gap_nxt;
  // Cycles since the last sample pulse, saturating
  always_comb begin
    gap_nxt = gap_r;
    if (analog_ctl.sample_hold)
      gap_nxt = 6'h00;
    else if (gap_r != 6'h3f)
      gap_nxt = gap_r + 6'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      gap_r <= 6'h3f;
    else
      gap_r <= gap_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ready_wait_a: assert property (apb_req.psel && apb_req.penable &&
    !apb_rsp.pready |=> apb_rsp.pready) else $error("pready late");
  data_idle_a: assert property (!apb_rsp.pready |->
    apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr) else $error("stray data");
  hold_pulse_a: assert property ($rose(analog_ctl.sample_hold) |=>
    !analog_ctl.sample_hold) else $error("sample pulse too long");
  chan_hold_a: assert property (analog_ctl.sample_hold |=>
    $stable(analog_ctl.channel) [*8]) else $error("channel moved");
  sample_gap_a: assert property (analog_ctl.sample_hold |->
    gap_r >= 6'd25) else $error("samples too close");
  ack_clear_a: assert property (irq_ack && !analog_ctl.dac_valid |->
    ##[1:2] !conversion_done_irq) else $error("flag not cleared");
  wake_clear_a: assert property (!cpu_halted |=> !wake_request)
    else $error("wake held");
  wake_cause_a: assert property ($rose(wake_request) |->
    ##[0:2] conversion_done_irq) else $error("wake without flag");
endmodule
bind sar_adc_sequencer sar_adc_monitor mon (.clk(clk), .reset_n(reset_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .comparator_in(comparator_in),
  .cpu_halted(cpu_halted), .irq_ack(irq_ack), .analog_ctl(analog_ctl),
  .conversion_done_irq(conversion_done_irq), .wake_request(wake_request));
`default_nettype wire

// >>> tb/analog_model.sv
// Analog front end model: channel sources, sample-and-hold, comparator
`default_nettype none
module analog_model (
  input wire logic clk,
  input wire sar_adc_pkg::analog_ctl_t analog_ctl,
  output wire logic comparator_in
);
  import sar_adc_pkg::*;
  logic [9:0] held_r = 10'h000;
  logic tog_r = 1'b0;
  always @(posedge clk) begin
    tog_r <= ~tog_r;
    if (analog_ctl.sample_hold)
      held_r <= {analog_ctl.channel[1:0], 8'h5a} + 10'(analog_ctl.channel);
  end
  // Source sits half a step above its code; output wanders when unused
  assign comparator_in = analog_ctl.dac_valid ?
    ({held_r, 1'b1} > {analog_ctl.trial, 1'b0}) : tog_r;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the SAR ADC sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_adc_pkg::*;
  logic clk;
  logic reset_n;
  logic halt;
  logic ack;
  logic cmp;
  logic irq;
  logic wake;
  apb_req_t req;
  apb_rsp_t rsp;
  analog_ctl_t ana;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int total_checks = 0;
  int c;
  sar_adc_sequencer DUT (.clk(clk), .reset_n(reset_n), .apb_req(req),
    .apb_rsp(rsp), .comparator_in(cmp), .cpu_halted(halt),
    .irq_ack(ack), .analog_ctl(ana), .conversion_done_irq(irq),
    .wake_request(wake));
  analog_model front (.clk(clk), .analog_ctl(ana), .comparator_in(cmp));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        check(32'h1, 32'h0);
        stop_test();
      end
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  // Counts cycles until the flag or the wake line goes high
  task automatic wt(input logic on_wake, input int lim);
    c = 0;
    while ((on_wake ? wake : irq) !== 1'b1) begin
      @(posedge clk);
      c++;
      if (c > lim) begin
        check(32'h1, 32'h0);
        stop_test();
      end
    end
  endtask
  task automatic res_chk(input logic [2:0] ch);
    logic [9:0] v;
    v = {ch[1:0], 8'h5a} + 10'(ch);
    apb(0, 12'h008, 8'h00);
    check(rd, {24'h0, v[7:0]});
    apb(0, 12'h00c, 8'h00);
    check(rd, {30'h0, v[9:8]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1, 12'h008, 8'hff);
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 12'(a), 8'h00);
      check(rd, 32'h0);
    end
    apb(0, 12'h010, 8'h00);
    check({31'h0, err}, 32'h1);
    for (int k = 0; k < 6; k++) begin
      apb(1, 12'h000, 8'(k));
      apb(0, 12'h000, 8'h00);
      check(rd, 32'(k));
    end
  endtask
  task automatic t_first();
    apb(1, 12'h000, 8'h01);
    // Divide by 4 at least: the comparator needs two sync flops per bit
    apb(1, 12'h004, 8'hca);
    apb(0, 12'h004, 8'h00);
    check(rd, 32'hca);
    wt(0, 150);
    check(32'(c > 90 && c < 106), 32'h1);
    res_chk(3'h1);
    apb(0, 12'h004, 8'h00);
    check(rd, 32'h9a);
    apb(1, 12'h004, 8'h9a);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic t_chg();
    apb(1, 12'h004, 8'hca);
    apb(1, 12'h000, 8'h02);
    apb(1, 12'h004, 8'h8a);
    apb(0, 12'h004, 8'h00);
    check(rd, 32'hca);
    wt(0, 90);
    check(32'(c > 35 && c < 48), 32'h1);
    res_chk(3'h1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    apb(1, 12'h004, 8'hcb);
    wt(0, 160);
    check(32'(c > 100 && c < 116), 32'h1);
    res_chk(3'h2);
  endtask
  task automatic t_lock();
    apb(1, 12'h004, 8'hfa);
    wt(0, 90);
    apb(0, 12'h008, 8'h00);
    check(rd, 32'h5c);
    apb(1, 12'h000, 8'h00);
    repeat (2) begin
      apb(1, 12'h004, 8'hba);
      wt(0, 70);
    end
    apb(0, 12'h00c, 8'h00);
    check(rd, 32'h2);
    apb(1, 12'h004, 8'hba);
    wt(0, 70);
    res_chk(3'h0);
    apb(1, 12'h004, 8'h00);
  endtask
  task automatic t_idle();
    apb(1, 12'h004, 8'h9a);
    halt <= 1'b1;
    wt(1, 150);
    check({31'h0, irq}, 32'h1);
    halt <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, wake}, 32'h0);
    res_chk(3'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    req = '0;
    halt = 1'b0;
    ack = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_first();
    t_chg();
    t_lock();
    t_idle();
    stop_test();
  end
endmodule
`default_nettype wire
